// [bench/ptrig_far_model.sv]
// Far-side model: external pause and sequence terminals and the sampled data channels.
// Assumes the bench sets the wanted levels at clock edges; pins move later, off the edge.
`timescale 1ns/1ps
module ptrig_far_model (
  input wire logic clk,
  input wire logic want_pause, // Level asked for the pause terminal
  input wire logic [3:0] want_seq, // Levels asked for the sequence terminals
  input wire logic [19:0] want_data, // Levels asked for the data channels
  output logic pause_src,
  output logic [3:0] seq_src,
  output logic [19:0] data_in
);
  // Terminals are known and idle low from time zero
  initial begin
    pause_src = 1'b0;
    seq_src = 4'h0;
    data_in = 20'h00000;
  end
  // Pins change 7 ns after the edge, so the block meets truly asynchronous inputs
  always @(posedge clk) begin
    pause_src <= #7 want_pause;
    seq_src <= #7 want_seq;
    data_in <= #7 want_data;
  end
endmodule

// [bench/ptrig_top_tb_top.sv]
// Bench top for the pause and sequence trigger block: register tasks, scenarios, verdict.
// Assumes ptrig_pkg, ptrig_top and ptrig_far_model are compiled first; 50 MHz sample clock.
`timescale 1ns/1ps
module ptrig_top_tb_top;
  logic clk = 1'b0; // Sample clock
  logic resetn = 1'b0; // Async reset, active low
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic want_pause = 1'b0; // Levels asked of the far side
  logic [3:0] want_seq = 4'h0;
  logic [19:0] want_data = 20'h00000;
  logic pause_src;
  logic [3:0] seq_src;
  logic [19:0] data_in;
  logic pause_out;
  logic [3:0] seq_trig_out;
  logic config_err;
  logic hit; // Pulse seen during the last watch
  logic [31:0] rv; // Last read value
  int n_fail = 0;
  int n_checks = 0;
  always #10 clk = ~clk;
  ptrig_top ptrig_top_inst (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .pause_src(pause_src), .seq_src(seq_src), .data_in(data_in), .pause_out(pause_out),
    .seq_trig_out(seq_trig_out), .config_err(config_err));
  ptrig_far_model ptrig_far_model_inst (.clk(clk), .want_pause(want_pause), .want_seq(want_seq),
    .want_data(want_data), .pause_src(pause_src), .seq_src(seq_src), .data_in(data_in));
  // Single comparison point; case inequality keeps unknowns from passing
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // One-cycle write strobe; the gap edge avoids a double assignment of wr
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe is taken
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask
  function automatic logic [31:0] pcfg(input logic [7:0] cond, input logic [7:0] lvl, input logic [1:0] m);
    return {8'h00, cond, lvl, 6'h00, m};
  endfunction
  function automatic logic [31:0] scfg(input logic [1:0] i, input logic [7:0] code, input logic [1:0] m);
    return {6'h00, i, 8'h00, code, 6'h00, m};
  endfunction
  task automatic chk_err(input logic e);
    @(posedge clk);
    #1 chk("config_err", {31'h0, config_err}, {31'h0, e});
  endtask
  // Bounded wait for the pause output; running out ends the run
  task automatic wait_pause(input logic e);
    #1;
    for (int i = 0; i < 10 && pause_out !== e; i++) begin
      @(posedge clk);
      #1;
    end
    chk("pause_out", {31'h0, pause_out}, {31'h0, e});
    if (pause_out !== e) end_of_test();
  endtask
  // Watch one sequence output for a pulse over eight cycles
  task automatic catch_seq(input int i, input logic e);
    hit = 1'b0;
    // Look first: a software pulse stands only in the cycle right after the write edge
    repeat (8) begin
      #1 if (seq_trig_out[i] === 1'b1) hit = 1'b1;
      @(posedge clk);
    end
    chk("seq_trig_out", {31'h0, hit}, {31'h0, e});
  endtask
  task automatic t_level_pause();
    rd_reg(ptrig_pkg::PTRIG_STATUS_OFS);
    chk("status after reset", rv, 32'h0000_0000);
    rd_reg(ptrig_pkg::PTRIG_SEQ_CFG_OFS);
    chk("seq config after reset", rv, 32'h0000_0000);
    wr_reg(ptrig_pkg::PTRIG_PAUSE_CFG_OFS, pcfg(ptrig_pkg::PTRIG_COND_ON_MATCH, ptrig_pkg::PTRIG_LEVEL_ACTIVE_HIGH,
      ptrig_pkg::PTRIG_PMODE_LEVEL));
    @(posedge clk) want_pause <= 1'b1;
    wait_pause(1'b1);
    @(posedge clk) want_pause <= 1'b0;
    wait_pause(1'b0);
    wr_reg(ptrig_pkg::PTRIG_PAUSE_CFG_OFS, pcfg(ptrig_pkg::PTRIG_COND_ON_MATCH, ptrig_pkg::PTRIG_LEVEL_ACTIVE_LOW,
      ptrig_pkg::PTRIG_PMODE_LEVEL));
    wait_pause(1'b1);
    rd_reg(ptrig_pkg::PTRIG_STATUS_OFS);
    chk("status low level", rv, 32'h0000_0003);
    wr_reg(ptrig_pkg::PTRIG_PAUSE_CFG_OFS, 32'h0000_0000);
    repeat (6) @(posedge clk);
    #1 chk("pause disabled", {31'h0, pause_out}, 32'h0);
  endtask
  task automatic t_patterns();
    wr_reg(ptrig_pkg::PTRIG_SESSION_OFS, {30'h0, ptrig_pkg::PTRIG_SESS_GEN_SCRIPT});
    wr_reg(ptrig_pkg::PTRIG_PAUSE_CFG_OFS, pcfg(ptrig_pkg::PTRIG_COND_ON_MATCH, ptrig_pkg::PTRIG_LEVEL_ACTIVE_HIGH,
      ptrig_pkg::PTRIG_PMODE_BINARY));
    chk_err(1'b1);
    wr_reg(ptrig_pkg::PTRIG_SESSION_OFS, {30'h0, ptrig_pkg::PTRIG_SESS_ACQ});
    wr_reg(ptrig_pkg::PTRIG_PAT_MASK_OFS, 32'h0000_0003);
    wr_reg(ptrig_pkg::PTRIG_PAT_VAL_OFS, 32'h0000_0001);
    @(posedge clk) want_data <= 20'hffff1;
    wr_reg(ptrig_pkg::PTRIG_PAUSE_CFG_OFS, pcfg(ptrig_pkg::PTRIG_COND_ON_MATCH, ptrig_pkg::PTRIG_LEVEL_ACTIVE_HIGH,
      ptrig_pkg::PTRIG_PMODE_BINARY));
    chk_err(1'b0);
    wait_pause(1'b1);
    wr_reg(ptrig_pkg::PTRIG_PAUSE_CFG_OFS, pcfg(ptrig_pkg::PTRIG_COND_ON_MISMATCH,
      ptrig_pkg::PTRIG_LEVEL_ACTIVE_HIGH, ptrig_pkg::PTRIG_PMODE_BINARY));
    wait_pause(1'b0);
    // Channel 1 listed first: qualifier one lands on channel 1, zero on channel 0
    wr_reg(ptrig_pkg::PTRIG_CHLIST_OFS, 32'h0002_0001);
    wr_reg(ptrig_pkg::PTRIG_CHLIST_OFS, 32'h0002_0100);
    wr_reg(ptrig_pkg::PTRIG_QUAL_LO_OFS, 32'h1800_0011);
    wr_reg(ptrig_pkg::PTRIG_QUAL_HI_OFS, 32'h0000_0000);
    wr_reg(ptrig_pkg::PTRIG_COMMIT_OFS, 32'h0000_0000);
    chk_err(1'b1);
    wr_reg(ptrig_pkg::PTRIG_QUAL_LO_OFS, 32'h1000_0011);
    wr_reg(ptrig_pkg::PTRIG_COMMIT_OFS, 32'h0000_0000);
    chk_err(1'b0);
    // Pattern goes live while channels 1,0 read 0,1, so pause starts low and must rise on the data change
    wr_reg(ptrig_pkg::PTRIG_PAUSE_CFG_OFS, pcfg(ptrig_pkg::PTRIG_COND_ON_MATCH, ptrig_pkg::PTRIG_LEVEL_ACTIVE_HIGH,
      ptrig_pkg::PTRIG_PMODE_PATTERN));
    @(posedge clk) want_data <= 20'h00002;
    wait_pause(1'b1);
    @(posedge clk) want_data <= 20'h00001;
    wait_pause(1'b0);
  endtask
  task automatic t_seq();
    wr_reg(ptrig_pkg::PTRIG_SEQ_CFG_OFS, scfg(2'h0, ptrig_pkg::PTRIG_EDGE_RISE_SELECT, ptrig_pkg::PTRIG_SMODE_EDGE));
    chk_err(1'b1);
    wr_reg(ptrig_pkg::PTRIG_SESSION_OFS, {30'h0, ptrig_pkg::PTRIG_SESS_GEN_SCRIPT});
    for (int i = 0; i < 4; i++) begin
      wr_reg(ptrig_pkg::PTRIG_SEQ_CFG_OFS, scfg(i[1:0], ptrig_pkg::PTRIG_EDGE_RISE_SELECT, ptrig_pkg::PTRIG_SMODE_EDGE));
      @(posedge clk) want_seq[i] <= 1'b1;
      catch_seq(i, 1'b1);
      @(posedge clk) want_seq[i] <= 1'b0;
      catch_seq(i, 1'b0);
    end
    wr_reg(ptrig_pkg::PTRIG_SEQ_CFG_OFS, scfg(2'h2, ptrig_pkg::PTRIG_EDGE_FALL_SELECT, ptrig_pkg::PTRIG_SMODE_EDGE));
    @(posedge clk) want_seq[2] <= 1'b1;
    catch_seq(2, 1'b0);
    @(posedge clk) want_seq[2] <= 1'b0;
    catch_seq(2, 1'b1);
    wr_reg(ptrig_pkg::PTRIG_SW_OFS, {6'h00, 2'h2, 16'h0000, ptrig_pkg::PTRIG_SEQUENCE_TRIG_SELECT_CODE});
    catch_seq(2, 1'b1);
    wr_reg(ptrig_pkg::PTRIG_SEQ_CFG_OFS, scfg(2'h1, ptrig_pkg::PTRIG_LEVEL_ACTIVE_LOW, ptrig_pkg::PTRIG_SMODE_LEVEL));
    catch_seq(1, 1'b1);
    @(posedge clk) want_seq[1] <= 1'b1;
    repeat (6) @(posedge clk);
    #1 chk("level trigger released", {31'h0, seq_trig_out[1]}, 32'h0);
    wr_reg(ptrig_pkg::PTRIG_SEQ_CFG_OFS, scfg(2'h0, 8'h00, ptrig_pkg::PTRIG_SMODE_SW));
    wr_reg(ptrig_pkg::PTRIG_SW_OFS, {24'h000000, ptrig_pkg::PTRIG_SEQUENCE_TRIG_SELECT_CODE});
    catch_seq(0, 1'b1);
    wr_reg(ptrig_pkg::PTRIG_SEQ_CFG_OFS, scfg(2'h3, 8'h00, ptrig_pkg::PTRIG_SMODE_OFF));
    @(posedge clk) want_seq[3] <= 1'b1;
    catch_seq(3, 1'b0);
    wr_reg(ptrig_pkg::PTRIG_SW_OFS, {6'h00, 2'h3, 16'h0000, ptrig_pkg::PTRIG_SEQUENCE_TRIG_SELECT_CODE});
    catch_seq(3, 1'b0);
  endtask
  // Main sequence: two cycles of reset, then the scenarios
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    t_level_pause();
    t_patterns();
    t_seq();
    end_of_test();
  end
  // Guard against a hang anywhere in the run
  initial begin
    #1ms;
    n_fail++;
    end_of_test();
  end
endmodule

// [src/ptrig_chan_match.sv]
// One channel of the pattern comparator: qualifier against current and previous sample.
// Assumes samples are already synchronised to clk.
`timescale 1ns/1ps
module ptrig_chan_match (
  input wire logic [2:0] qual,
  input wire logic cur,
  input wire logic prev,
  output logic ok
);
  // Combinational match per qualifier
  always_comb begin
    unique case (ptrig_pkg::ptrig_qual_t'(qual))
      ptrig_pkg::PTRIG_Q_IGNORE: ok = 1'b1;
      ptrig_pkg::PTRIG_Q_ONE: ok = cur;
      ptrig_pkg::PTRIG_Q_ZERO: ok = !cur;
      ptrig_pkg::PTRIG_Q_RISE: ok = cur && !prev;
      ptrig_pkg::PTRIG_Q_FALL: ok = !cur && prev;
      ptrig_pkg::PTRIG_Q_EITHER: ok = cur ^ prev;
      default: ok = 1'b1; // Codes 6,7 treated as ignore
    endcase
  end
endmodule

// [src/ptrig_pkg.sv]
// Package for the pause and sequence trigger block: register map, codes, field layout.
// Assumes a plain address/strobe register port, 32-bit data, one sample clock.
package ptrig_pkg;
  // Register byte offsets
  localparam logic [7:0] PTRIG_PAUSE_CFG_OFS = 8'h00; // Pause mode, polarity, condition
  localparam logic [7:0] PTRIG_PAT_MASK_OFS = 8'h04; // Binary pattern channel mask
  localparam logic [7:0] PTRIG_PAT_VAL_OFS = 8'h08; // Binary pattern value
  localparam logic [7:0] PTRIG_QUAL_LO_OFS = 8'h0c; // Qualifiers, list positions 0..9
  localparam logic [7:0] PTRIG_QUAL_HI_OFS = 8'h10; // Qualifiers, list positions 10..19
  localparam logic [7:0] PTRIG_CHLIST_OFS = 8'h14; // Channel list entry write
  localparam logic [7:0] PTRIG_COMMIT_OFS = 8'h18; // Commit string pattern
  localparam logic [7:0] PTRIG_SEQ_CFG_OFS = 8'h1c; // Sequence trigger config
  localparam logic [7:0] PTRIG_SW_OFS = 8'h20; // Software trigger command
  localparam logic [7:0] PTRIG_STATUS_OFS = 8'h24; // Status
  localparam logic [7:0] PTRIG_SESSION_OFS = 8'h28; // Session kind
  // Codes
  localparam logic [7:0] PTRIG_EDGE_RISE_SELECT = 8'h0c; // 12
  localparam logic [7:0] PTRIG_EDGE_FALL_SELECT = 8'h0d; // 13
  localparam logic [7:0] PTRIG_LEVEL_ACTIVE_HIGH = 8'h22; // 34
  localparam logic [7:0] PTRIG_LEVEL_ACTIVE_LOW = 8'h23; // 35
  localparam logic [7:0] PTRIG_COND_ON_MATCH = 8'h24; // 36
  localparam logic [7:0] PTRIG_COND_ON_MISMATCH = 8'h25; // 37
  localparam logic [7:0] PTRIG_SEQUENCE_TRIG_SELECT_CODE = 8'h3a; // 58
  // Pause modes (cfg bits 1:0)
  localparam logic [1:0] PTRIG_PMODE_OFF = 2'h0;
  localparam logic [1:0] PTRIG_PMODE_LEVEL = 2'h1;
  localparam logic [1:0] PTRIG_PMODE_PATTERN = 2'h2;
  localparam logic [1:0] PTRIG_PMODE_BINARY = 2'h3;
  // Sequence trigger modes
  localparam logic [1:0] PTRIG_SMODE_OFF = 2'h0;
  localparam logic [1:0] PTRIG_SMODE_EDGE = 2'h1;
  localparam logic [1:0] PTRIG_SMODE_LEVEL = 2'h2;
  localparam logic [1:0] PTRIG_SMODE_SW = 2'h3;
  // Session kinds
  localparam logic [1:0] PTRIG_SESS_ACQ = 2'h1;
  localparam logic [1:0] PTRIG_SESS_GEN_SCRIPT = 2'h3;
  // Field positions
  localparam int PTRIG_MODE_LSB = 0;
  localparam int PTRIG_CODE_A_LSB = 8;
  localparam int PTRIG_CODE_B_LSB = 16;
  localparam int PTRIG_IDX_LSB = 24;
  localparam int PTRIG_QUAL_W = 3;
  localparam int PTRIG_QUAL_PER_REG = 10;
  // Qualifier codes
  typedef enum logic [2:0] {
    PTRIG_Q_IGNORE = 3'h0, PTRIG_Q_ONE = 3'h1, PTRIG_Q_ZERO = 3'h2,
    PTRIG_Q_RISE = 3'h3, PTRIG_Q_FALL = 3'h4, PTRIG_Q_EITHER = 3'h5
  } ptrig_qual_t;
  localparam logic [31:0] PTRIG_RD_ZERO = 32'h0000_0000;
endpackage

// [src/ptrig_sync.sv]
// Two-flop synchroniser for external trigger levels.
// Assumes the input is asynchronous to clk; only the second stage is used downstream.
`timescale 1ns/1ps
module ptrig_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg; // First stage, read only by q
  // Two-stage capture; first stage feeds nothing else
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// [src/ptrig_top.sv]
// Pause and sequence trigger qualification logic: registers, pattern match, four sequence triggers.
// Assumes one sample clock, async active-low reset, register port with read data one cycle later.
// Behaviour
// RL1 - Level pause holds operation while source active
// RL2 - Pause polarity 34 high, 35 low, default high
// RL3 - Pattern pause accepted only in acquisition
// RL4 - Six per-channel qualifiers
// RL5 - Trigger after transition; next full sample follows
// RL6 - First qualifier maps first listed channel
// RL7 - Qualifier/channel count mismatch rejected, not applied
// RL8 - Condition 36 match, 37 mismatch, default match
// RL9 - Binary pattern form, high/low only
// RL10 - Unselected channels ignored in binary form
// RL11 - Disabled pause never pauses
// RL12 - Four sequence triggers, index defaults zero
// RL13 - Edge mode 12 rise, 13 fall, default rise
// RL14 - Level mode 34 high, 35 low, default high
// RL15 - Sequence config only in scripted generation; the code also accepts mode off in any session
// RL16 - Disabled sequence trigger never asserts
// RL17 - Software command 58 forces trigger immediately
// RL18 - Sources synchronised; edges compare previous sample
`timescale 1ns/1ps
module ptrig_top #(
  parameter int NCH = 20, // Data channels
  parameter int NSEQ = 4 // Sequence triggers
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic pause_src, // External pause terminal
  input wire logic [NSEQ-1:0] seq_src, // External sequence trigger terminals
  input wire logic [NCH-1:0] data_in, // Sampled data channels
  output logic pause_out, // Operation suspended
  output logic [NSEQ-1:0] seq_trig_out, // Sequence trigger asserted
  output logic config_err // Last configuration was rejected
);
  localparam int QW = ptrig_pkg::PTRIG_QUAL_W;
  localparam int LW = $clog2(NCH + 1);

  // Synchronised inputs
  logic pause_s;
  logic [NSEQ-1:0] seq_s;
  logic [NCH-1:0] data_s;
  ptrig_sync #(.W(1 + NSEQ + NCH)) u_sync ( // [RL18]
    .clk(clk), .resetn(resetn),
    .d({pause_src, seq_src, data_in}),
    .q({pause_s, seq_s, data_s})
  );

  // Configuration state
  logic [1:0] session_reg; // Session kind
  logic [1:0] pmode_reg; // Pause mode
  logic pause_pol_low_reg; // 1 = active-low
  logic cond_mismatch_reg; // 1 = assert on mismatch
  logic [NCH-1:0] bin_mask_reg; // Binary form channel selection
  logic [NCH-1:0] bin_val_reg; // Binary form values
  logic [NCH*QW-1:0] qual_stage_reg; // Qualifiers by list position, staged
  logic [NCH*QW-1:0] qual_reg; // Qualifiers by physical channel, live
  logic [NCH*QW-1:0] qual_next;
  logic [NCH*5-1:0] chlist_reg; // Listed channel numbers by position
  logic [LW-1:0] chcount_reg; // Number of listed channels
  logic [LW-1:0] qcount_reg; // Number of qualifiers written
  logic [1:0] seq_idx_reg; // Selected sequence index
  logic [NSEQ*2-1:0] smode_reg; // Mode per sequence trigger
  logic [NSEQ-1:0] sfall_reg; // Edge select: 1 = falling
  logic [NSEQ-1:0] slow_reg; // Level select: 1 = low
  logic config_err_next;

  // Decoded write fields
  logic [7:0] code_a;
  logic [7:0] code_b;
  logic [1:0] wmode;
  logic [1:0] widx;
  assign code_a = wdata[ptrig_pkg::PTRIG_CODE_A_LSB +: 8];
  assign code_b = wdata[ptrig_pkg::PTRIG_CODE_B_LSB +: 8];
  assign wmode = wdata[ptrig_pkg::PTRIG_MODE_LSB +: 2];
  assign widx = wdata[ptrig_pkg::PTRIG_IDX_LSB +: 2];

  logic is_acq;
  logic is_script;
  assign is_acq = session_reg == ptrig_pkg::PTRIG_SESS_ACQ;
  assign is_script = session_reg == ptrig_pkg::PTRIG_SESS_GEN_SCRIPT;

  logic pause_wr;
  logic pause_ok; // Pause config legal for this session
  assign pause_wr = wr && addr == ptrig_pkg::PTRIG_PAUSE_CFG_OFS;
  // Pattern sources only in acquisition; codes must be legal
  always_comb begin
    pause_ok = 1'b1;
    if ((wmode == ptrig_pkg::PTRIG_PMODE_PATTERN || wmode == ptrig_pkg::PTRIG_PMODE_BINARY) && !is_acq) begin
      pause_ok = 1'b0; // [RL3]
    end
    if (wmode == ptrig_pkg::PTRIG_PMODE_LEVEL && code_a != ptrig_pkg::PTRIG_LEVEL_ACTIVE_HIGH &&
        code_a != ptrig_pkg::PTRIG_LEVEL_ACTIVE_LOW) begin
      pause_ok = 1'b0;
    end
    if (wmode[1] && code_b != ptrig_pkg::PTRIG_COND_ON_MATCH && code_b != ptrig_pkg::PTRIG_COND_ON_MISMATCH) begin
      pause_ok = 1'b0;
    end
    if (wmode == ptrig_pkg::PTRIG_PMODE_PATTERN && qcount_reg != chcount_reg) begin
      pause_ok = 1'b0; // [RL7]
    end
  end

  logic seq_wr;
  logic seq_ok;
  assign seq_wr = wr && addr == ptrig_pkg::PTRIG_SEQ_CFG_OFS;
  // Sequence config legal only in scripted generation, except mode off in any session, with legal codes
  always_comb begin
    seq_ok = is_script || wmode == ptrig_pkg::PTRIG_SMODE_OFF; // [RL15]
    if (wmode == ptrig_pkg::PTRIG_SMODE_EDGE && code_a != ptrig_pkg::PTRIG_EDGE_RISE_SELECT &&
        code_a != ptrig_pkg::PTRIG_EDGE_FALL_SELECT) begin
      seq_ok = 1'b0;
    end
    if (wmode == ptrig_pkg::PTRIG_SMODE_LEVEL && code_a != ptrig_pkg::PTRIG_LEVEL_ACTIVE_HIGH &&
        code_a != ptrig_pkg::PTRIG_LEVEL_ACTIVE_LOW) begin
      seq_ok = 1'b0;
    end
  end

  // Route list-position qualifiers to physical channels
  always_comb begin
    qual_next = '0;
    for (int p = 0; p < NCH; p++) begin
      // A listed channel number beyond the last channel is dropped rather than written out of range
      if (p < int'(chcount_reg) && int'(chlist_reg[p*5 +: 5]) < NCH) begin
        qual_next[int'(chlist_reg[p*5 +: 5])*QW +: QW] = qual_stage_reg[p*QW +: QW]; // [RL6]
      end
    end
  end

  // Session kind register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      session_reg <= 2'h0;
    end else if (wr && addr == ptrig_pkg::PTRIG_SESSION_OFS) begin
      session_reg <= wdata[1:0];
    end
  end

  // Pause configuration; rejected writes leave the old setting alone
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pmode_reg <= ptrig_pkg::PTRIG_PMODE_OFF;
      pause_pol_low_reg <= 1'b0; // [RL2]
      cond_mismatch_reg <= 1'b0; // [RL8]
    end else if (pause_wr && pause_ok) begin
      pmode_reg <= wmode;
      if (wmode == ptrig_pkg::PTRIG_PMODE_LEVEL) begin
        pause_pol_low_reg <= code_a == ptrig_pkg::PTRIG_LEVEL_ACTIVE_LOW; // [RL2]
      end
      if (wmode[1]) begin
        cond_mismatch_reg <= code_b == ptrig_pkg::PTRIG_COND_ON_MISMATCH; // [RL8]
      end
    end
  end

  // Pattern tables: staging, list, binary form; live qualifiers change only on an accepted commit
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      qual_stage_reg <= '0;
      qual_reg <= '0;
      chlist_reg <= '0;
      chcount_reg <= '0;
      qcount_reg <= '0;
      bin_mask_reg <= '0;
      bin_val_reg <= '0;
    end else if (wr) begin
      unique case (addr)
        ptrig_pkg::PTRIG_QUAL_LO_OFS: begin
          qual_stage_reg[0 +: 30] <= wdata[29:0];
          qcount_reg <= LW'(wdata[31:27] > 5'h0a ? 5'h0a : wdata[31:27]); // Count in top bits
        end
        ptrig_pkg::PTRIG_QUAL_HI_OFS: begin
          qual_stage_reg[30 +: 30] <= wdata[29:0];
          qcount_reg <= LW'(ptrig_pkg::PTRIG_QUAL_PER_REG) + LW'(wdata[31:30] == 2'h0 ? 5'h00 : {3'h0, wdata[31:30]})
                        + LW'(wdata[31:30] == 2'h3 ? 5'h07 : 5'h00);
        end
        ptrig_pkg::PTRIG_CHLIST_OFS: begin
          if (wdata[12:8] < 5'(NCH)) begin
            chlist_reg[int'(wdata[12:8])*5 +: 5] <= wdata[4:0]; // Position in 12:8, channel in 4:0
            chcount_reg <= LW'(wdata[20:16]);
          end
        end
        ptrig_pkg::PTRIG_COMMIT_OFS: begin
          if (qcount_reg == chcount_reg) begin
            qual_reg <= qual_next; // [RL7]
          end
        end
        ptrig_pkg::PTRIG_PAT_MASK_OFS: bin_mask_reg <= wdata[NCH-1:0];
        ptrig_pkg::PTRIG_PAT_VAL_OFS: bin_val_reg <= wdata[NCH-1:0]; // [RL9]
        default: ;
      endcase
    end
  end

  // Error flag: set by any rejected configuration, cleared by an accepted one
  always_comb begin
    config_err_next = config_err;
    if (pause_wr) config_err_next = !pause_ok;
    if (seq_wr) config_err_next = !seq_ok;
    if (wr && addr == ptrig_pkg::PTRIG_COMMIT_OFS) config_err_next = qcount_reg != chcount_reg; // [RL7]
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) config_err <= 1'b0;
    else config_err <= config_err_next;
  end

  // Sequence trigger configuration
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      seq_idx_reg <= 2'h0; // [RL12]
      smode_reg <= '0;
      sfall_reg <= '0; // [RL13]
      slow_reg <= '0; // [RL14]
    end else if (seq_wr) begin
      seq_idx_reg <= widx; // [RL12]
      if (seq_ok) begin
        smode_reg[widx*2 +: 2] <= wmode; // [RL16]
        if (wmode == ptrig_pkg::PTRIG_SMODE_EDGE) sfall_reg[widx] <= code_a == ptrig_pkg::PTRIG_EDGE_FALL_SELECT;
        if (wmode == ptrig_pkg::PTRIG_SMODE_LEVEL) slow_reg[widx] <= code_a == ptrig_pkg::PTRIG_LEVEL_ACTIVE_LOW;
      end
    end
  end

  // Previous sample for edge qualifiers
  logic [NCH-1:0] data_prev_reg;
  logic [NSEQ-1:0] seq_prev_reg;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      data_prev_reg <= '0;
      seq_prev_reg <= '0;
    end else begin
      data_prev_reg <= data_s; // [RL18]
      seq_prev_reg <= seq_s;
    end
  end

  // Per-channel comparators
  logic [NCH-1:0] chan_ok;
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      ptrig_chan_match u_m ( // [RL4]
        .qual(qual_reg[g*QW +: QW]), .cur(data_s[g]), .prev(data_prev_reg[g]), .ok(chan_ok[g])
      );
    end
  endgenerate

  // Match decision for the active pattern form
  logic pat_match;
  logic pat_hit;
  always_comb begin
    if (pmode_reg == ptrig_pkg::PTRIG_PMODE_BINARY) begin
      pat_match = ((data_s ^ bin_val_reg) & bin_mask_reg) == '0; // [RL10]
    end else begin
      pat_match = &chan_ok; // [RL5]
    end
    pat_hit = pat_match ^ cond_mismatch_reg; // [RL8]
  end

  // Pause output; asserts the cycle after a matching transition so the next full sample is taken
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pause_out <= 1'b0;
    end else begin
      unique case (pmode_reg)
        ptrig_pkg::PTRIG_PMODE_OFF: pause_out <= 1'b0; // [RL11]
        ptrig_pkg::PTRIG_PMODE_LEVEL: pause_out <= pause_s ^ pause_pol_low_reg; // [RL1]
        default: pause_out <= pat_hit; // [RL5]
      endcase
    end
  end

  // Sequence trigger outputs with software force
  logic sw_hit;
  assign sw_hit = wr && addr == ptrig_pkg::PTRIG_SW_OFS && wdata[7:0] == ptrig_pkg::PTRIG_SEQUENCE_TRIG_SELECT_CODE;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      seq_trig_out <= '0;
    end else begin
      for (int i = 0; i < NSEQ; i++) begin
        unique case (smode_reg[i*2 +: 2])
          ptrig_pkg::PTRIG_SMODE_OFF: seq_trig_out[i] <= 1'b0; // [RL16]
          ptrig_pkg::PTRIG_SMODE_EDGE: seq_trig_out[i] <= (sw_hit && widx == 2'(i)) ||
            (sfall_reg[i] ? (!seq_s[i] && seq_prev_reg[i]) : (seq_s[i] && !seq_prev_reg[i])); // [RL13]
          ptrig_pkg::PTRIG_SMODE_LEVEL: seq_trig_out[i] <= (sw_hit && widx == 2'(i)) ||
            (seq_s[i] ^ slow_reg[i]); // [RL14]
          default: seq_trig_out[i] <= sw_hit && widx == 2'(i); // [RL17]
        endcase
      end
    end
  end

  // Register read, data one cycle after the strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= ptrig_pkg::PTRIG_RD_ZERO;
    end else if (rd) begin
      unique case (addr)
        ptrig_pkg::PTRIG_PAUSE_CFG_OFS: rdata <= {30'h0, pmode_reg};
        ptrig_pkg::PTRIG_PAT_MASK_OFS: rdata <= 32'(bin_mask_reg);
        ptrig_pkg::PTRIG_PAT_VAL_OFS: rdata <= 32'(bin_val_reg);
        ptrig_pkg::PTRIG_SEQ_CFG_OFS: rdata <= {22'h0, seq_idx_reg, smode_reg};
        ptrig_pkg::PTRIG_STATUS_OFS: rdata <= {24'h0, seq_trig_out, 1'b0, config_err, pause_pol_low_reg, pause_out};
        ptrig_pkg::PTRIG_SESSION_OFS: rdata <= {30'h0, session_reg};
        default: rdata <= ptrig_pkg::PTRIG_RD_ZERO;
      endcase
    end else begin
      rdata <= ptrig_pkg::PTRIG_RD_ZERO;
    end
  end

  // Checks
  property p_pause_off;
    @(posedge clk) disable iff (!resetn) pmode_reg == ptrig_pkg::PTRIG_PMODE_OFF |=> !pause_out;
  endproperty
  a_pause_off: assert property (p_pause_off) else $error("pause while disabled"); // [RL11]
  property p_seq_off;
    @(posedge clk) disable iff (!resetn) smode_reg[1:0] == ptrig_pkg::PTRIG_SMODE_OFF |=> !seq_trig_out[0];
  endproperty
  a_seq_off: assert property (p_seq_off) else $error("disabled sequence trigger asserted"); // [RL16]
  property p_level;
    @(posedge clk) disable iff (!resetn) pmode_reg == ptrig_pkg::PTRIG_PMODE_LEVEL && $stable(pmode_reg)
      |=> pause_out == ($past(pause_s) ^ $past(pause_pol_low_reg));
  endproperty
  a_level: assert property (p_level) else $error("level pause wrong"); // [RL1]
  property p_sw;
    @(posedge clk) disable iff (!resetn) sw_hit && widx == 2'h0 && smode_reg[1:0] != ptrig_pkg::PTRIG_SMODE_OFF
      |=> seq_trig_out[0];
  endproperty
  a_sw: assert property (p_sw) else $error("software trigger lost"); // [RL17]
  property p_reject;
    @(posedge clk) disable iff (!resetn) pause_wr && !pause_ok |=> $stable(pmode_reg) && config_err;
  endproperty
  a_reject: assert property (p_reject) else $error("rejected config applied"); // [RL7]
  // A pattern form may stay live after the session kind changes; only taking it up needs acquisition
  property p_acq;
    @(posedge clk) disable iff (!resetn) pmode_reg[1] && $changed(pmode_reg) |-> $past(is_acq);
  endproperty
  a_acq: assert property (p_acq) else $error("pattern pause outside acquisition"); // [RL3]
  property p_seqcfg;
    @(posedge clk) disable iff (!resetn) seq_wr && !is_script && wmode != ptrig_pkg::PTRIG_SMODE_OFF
      |=> $stable(smode_reg);
  endproperty
  a_seqcfg: assert property (p_seqcfg) else $error("sequence config outside script"); // [RL15]
  property p_edge;
    @(posedge clk) disable iff (!resetn) smode_reg[1:0] == ptrig_pkg::PTRIG_SMODE_EDGE && !sfall_reg[0]
      && seq_s[0] && !seq_prev_reg[0] |=> seq_trig_out[0];
  endproperty
  a_edge: assert property (p_edge) else $error("rising edge missed"); // [RL13]
endmodule
